// *** rtl/acp_conv_port.sv ***
// conversion control and parallel/serial result port of the converter
`timescale 1ns/1ps
module acp_conv_port #(
	parameter int CONV_CYC = acp_pkg::CONV_CYC_DEF, // conversion clocks
	parameter int QTR_CYC  = acp_pkg::QTR_CYC_DEF   // quarter bit clocks
) (
	input  wire logic                      sys_clk_in,    // system clock
	input  wire logic                      nrst_in,       // async reset
	input  wire logic                      cs_n_in,       // chip select
	input  wire logic                      rc_in,         // read/convert
	input  wire logic                      byte_sel_in,   // 1: low byte
	input  wire logic                      clock_source_select_in, // 1 ext
	input  wire logic                      output_format_select_in, // 1 sb
	input  wire logic                      power_down_in, // inhibit
	input  wire logic                      tag_in,        // daisy chain
	input  wire logic                      serial_shift_clock_in, // pin in
	input  wire logic [acp_pkg::RES_W-1:0] sample_data_in, // core result
	output logic      [acp_pkg::BYTE_W-1:0] parallel_data_out, // bus
	output logic                      parallel_oe_out, // bus enable
	output logic                      busy_n_out,      // low while busy
	output logic                      serial_shift_clock_out, // pin out
	output logic                      serial_shift_clock_oe_out, // drive
	output logic                      serial_result_out // serial data
);
	import acp_pkg::*;

	localparam int CW = $clog2(CONV_CYC + 1); // conversion counter
	localparam int QW = $clog2(QTR_CYC + 1);  // quarter counter

	if (CONV_CYC < 2) begin : g_bad_conv
		$error("CONV_CYC must be at least 2");
	end
	if (QTR_CYC < 1) begin : g_bad_qtr
		$error("QTR_CYC must be at least 1");
	end

	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [1:0]           cs_s;     // chip select sync
		logic [1:0]           rc_s;     // read/convert sync
		logic [1:0]           pd_s;     // power-down sync
		logic [1:0]           es_s;     // clock source sync
		logic [1:0]           bs_s;     // byte select sync
		logic [1:0]           fm_s;     // format sync
		logic [1:0]           tag_s;    // daisy chain sync
		logic [1:0]           lb_s;     // link bit sync
		logic                 act_prev; // convert level last cycle
		acp_state_t           st;       // sequencer
		logic [CW-1:0]        conv_cnt; // clocks left in conversion
		logic [RES_W-1:0]     result;   // last finished result
		logic                 upd_tgl;  // new result event
		logic                 ser_run;  // internal burst running
		logic [BIT_CNT_W-1:0] bit_cnt;  // burst bit index
		logic [1:0]           qtr;      // quarter within a bit
		logic [QW-1:0]        qcnt;     // clocks within a quarter
		logic [RES_W-1:0]     shreg;    // burst shift register
		logic                 rest;     // idle serial level
		logic [BYTE_W-1:0]    pdat;     // parallel out
		logic                 poe;      // parallel enable out
		logic                 busy_n;   // busy out
		logic                 sclk;     // shift clock out
		logic                 sclk_oe;  // shift clock drive
		logic                 sdo;      // serial data out
	} acp_core_t;

	acp_core_t        r_r;      // registered state
	acp_core_t        r_nxt;    // next state
	logic             act;      // convert level, both pins low
	logic             start;    // accepted conversion request
	logic [RES_W-1:0] word_now; // formatted current result
	logic [RES_W-1:0] word_nxt; // formatted next result

	acp_link_if lk ();

	////////////////////////////////////////////////////////////////////
	// link side, on the external shift clock
	acp_link_shift u_link (
		.link_clk_in (serial_shift_clock_in),
		.nrst_in     (nrst_in),
		.lk          (lk.link)
	);

	assign lk.word    = word_now;
	assign lk.upd_tgl = r_r.upd_tgl;
	assign lk.cs_n    = cs_n_in;
	assign lk.rc      = rc_in;
	assign lk.tag     = tag_in;

	// result coding follows the format pin
	assign word_now = acp_fmt(r_r.result, r_r.fm_s[1]);

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		r_nxt = r_r;
		// pin synchronisers
		r_nxt.cs_s  = {r_r.cs_s[0], cs_n_in};
		r_nxt.rc_s  = {r_r.rc_s[0], rc_in};
		r_nxt.pd_s  = {r_r.pd_s[0], power_down_in};
		r_nxt.es_s  = {r_r.es_s[0], clock_source_select_in};
		r_nxt.bs_s  = {r_r.bs_s[0], byte_sel_in};
		r_nxt.fm_s  = {r_r.fm_s[0], output_format_select_in};
		r_nxt.tag_s = {r_r.tag_s[0], tag_in};
		r_nxt.lb_s  = {r_r.lb_s[0], lk.ser_bit};

		// either pin falling while the other is low starts
		act = !r_r.cs_s[1] && !r_r.rc_s[1];
		start = act && !r_r.act_prev
			&& r_r.busy_n
			&& !r_r.pd_s[1];
		r_nxt.act_prev = act;

		// conversion sequencer
		case (r_r.st)
			ACP_IDLE: begin
				if (start) begin
					r_nxt.st       = ACP_CONV;
					r_nxt.conv_cnt = CW'(CONV_CYC - 1);
				end
			end
			ACP_CONV: begin
				if (r_r.conv_cnt == '0) begin
					r_nxt.st      = ACP_IDLE;
					r_nxt.result  = sample_data_in;
					r_nxt.upd_tgl = ~r_r.upd_tgl;
				end else begin
					r_nxt.conv_cnt = r_r.conv_cnt - CW'(1);
				end
			end
			default: begin
				r_nxt.st = ACP_IDLE;
			end
		endcase

		// internal burst: previous result goes out at each start
		if (start && !r_r.es_s[1]) begin
			r_nxt.ser_run = 1'b1;
			r_nxt.shreg   = word_now;
			r_nxt.rest    = r_r.tag_s[1];
			r_nxt.bit_cnt = '0;
			r_nxt.qtr     = '0;
			r_nxt.qcnt    = '0;
		end else if (r_r.ser_run) begin
			if (r_r.qcnt == QW'(QTR_CYC - 1)) begin
				r_nxt.qcnt = '0;
				r_nxt.qtr  = r_r.qtr + 2'd1;
				// data moves a quarter after the falling edge
				if (r_r.qtr == 2'd3) begin
					if (r_r.bit_cnt == BIT_CNT_W'(N_BITS - 1)) begin
						r_nxt.ser_run = 1'b0;
					end else begin
						r_nxt.bit_cnt = r_r.bit_cnt + BIT_CNT_W'(1);
						r_nxt.shreg = {r_r.shreg[MSB-1:0], 1'b0};
					end
				end
			end else begin
				r_nxt.qcnt = r_r.qcnt + QW'(1);
			end
		end

		// outputs, taken from the next state so they line up
		word_nxt = acp_fmt(r_nxt.result, r_r.fm_s[1]);
		r_nxt.busy_n = (r_nxt.st == ACP_IDLE) && !r_nxt.ser_run;
		r_nxt.poe = !r_r.cs_s[1] && r_r.rc_s[1];
		if (r_r.bs_s[1]) begin
			r_nxt.pdat = word_nxt[LO_BYTE +: BYTE_W];
		end else begin
			r_nxt.pdat = word_nxt[HI_BYTE +: BYTE_W];
		end
		r_nxt.sclk_oe = !r_r.es_s[1];
		r_nxt.sclk = r_nxt.ser_run
			&& (r_nxt.qtr == 2'd1 || r_nxt.qtr == 2'd2);
		if (r_r.es_s[1]) begin
			r_nxt.sdo = r_r.lb_s[1];
		end else if (r_nxt.ser_run) begin
			r_nxt.sdo = r_nxt.shreg[MSB];
		end else begin
			r_nxt.sdo = r_nxt.rest;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			// select pins rest high so no false start follows reset;
			// the source sync rests external so the clock pin is not
			// driven before the real level has been seen
			r_r        <= '0;
			r_r.busy_n <= BUSY_N_RST;
			r_r.cs_s   <= SYNC_HI_RST;
			r_r.rc_s   <= SYNC_HI_RST;
			r_r.es_s   <= SYNC_HI_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign parallel_data_out         = r_r.pdat;
	assign parallel_oe_out           = r_r.poe;
	assign busy_n_out                = r_r.busy_n;
	assign serial_shift_clock_out    = r_r.sclk;
	assign serial_shift_clock_oe_out = r_r.sclk_oe;
	assign serial_result_out         = r_r.sdo;

	////////////////////////////////////////////////////////////////////
	// checker helpers: count burst rising edges since the last start
	logic                 sclk_q;   // shift clock one cycle ago
	logic [BIT_CNT_W-1:0] edge_cnt; // rising edges this burst

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sclk_q   <= 1'b0;
			edge_cnt <= '0;
		end else begin
			sclk_q <= serial_shift_clock_out;
			if (start) begin
				edge_cnt <= '0;
			end else if (serial_shift_clock_out && !sclk_q) begin
				edge_cnt <= edge_cnt + BIT_CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking scb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);

	busy_start_a: assert property (
		start |=> !busy_n_out [*2])
		else $error("busy not low after start");

	conv_keep_a: assert property (
		r_r.st == ACP_CONV && r_r.conv_cnt != '0
		|=> r_r.st == ACP_CONV
			&& r_r.conv_cnt == $past(r_r.conv_cnt) - CW'(1))
		else $error("conversion disturbed while busy");

	pd_hold_a: assert property (
		r_r.pd_s[1] && r_r.st == ACP_IDLE
		|=> r_r.st == ACP_IDLE && $stable(r_r.result))
		else $error("conversion started in power-down");

	par_oe_a: assert property (
		parallel_oe_out == $past(!r_r.cs_s[1] && r_r.rc_s[1]))
		else $error("parallel enable wrong");

	byte_sel_a: assert property (
		$past(nrst_in)
		&& $stable(r_r.bs_s[1]) && $stable(r_r.fm_s[1])
		|-> parallel_data_out == (r_r.bs_s[1]
			? word_now[LO_BYTE +: BYTE_W] : word_now[HI_BYTE +: BYTE_W]))
		else $error("wrong byte on parallel bus");

	sclk_cnt_a: assert property (
		$fell(r_r.ser_run) |-> edge_cnt == BIT_CNT_W'(N_BITS))
		else $error("burst pulse count wrong");

	sclk_idle_a: assert property (
		!r_r.ser_run |-> !serial_shift_clock_out)
		else $error("shift clock not low between bursts");

	both_edge_a: assert property (
		$changed(serial_shift_clock_out) && $past(!r_r.es_s[1])
		&& !r_r.es_s[1] |-> $stable(serial_result_out))
		else $error("serial data moved on a clock edge");

	rest_tag_a: assert property (
		!r_r.ser_run && $past(!r_r.es_s[1])
		|-> serial_result_out == r_r.rest)
		else $error("idle serial level not captured tag");

	ser_start_a: assert property (
		start && !r_r.es_s[1] |=> r_r.ser_run && !busy_n_out)
		else $error("burst did not start with conversion");

	start_int_c: cover property (start && !r_r.es_s[1]);
	start_ext_c: cover property (start && r_r.es_s[1]);
	pd_refuse_c: cover property (act && !r_r.act_prev && r_r.pd_s[1]);
	busy_done_c: cover property ($rose(busy_n_out));

endmodule : acp_conv_port

// *** rtl/acp_pkg.sv ***
// constants, types and helpers shared by the conversion output port
package acp_pkg;

	localparam int RES_W        = 16;   // result width
	localparam int BYTE_W       = 8;    // parallel bus width
	localparam int N_BITS       = 16;   // serial bits per frame
	localparam int BIT_CNT_W    = 5;    // serial bit counter width
	localparam int CONV_CYC_DEF = 100;  // conversion length, sys clocks
	localparam int QTR_CYC_DEF  = 4;    // quarter of a serial bit
	localparam int MSB          = RES_W - 1;
	localparam int LO_BYTE      = 0;    // low byte lane start
	localparam int HI_BYTE      = 8;    // high byte lane start
	localparam logic BUSY_N_RST = 1'b1; // busy pin idle level
	localparam logic [1:0] SYNC_HI_RST = 2'h3; // idle-high pin sync

	// conversion sequencer states
	typedef enum logic {
		ACP_IDLE,
		ACP_CONV
	} acp_state_t;

	// raw core data is straight binary; two's complement flips the msb
	function automatic logic [RES_W-1:0] acp_fmt(
		input logic [RES_W-1:0] raw,
		input logic             sb
	);
		acp_fmt = sb ? raw : {~raw[MSB], raw[MSB-1:0]};
	endfunction : acp_fmt

endpackage : acp_pkg

// *** rtl/acp_link_if.sv ***
// carrier between the system-clock core and the serial link logic
`timescale 1ns/1ps
interface acp_link_if;

	logic [acp_pkg::RES_W-1:0] word;    // formatted result, quasi-static
	logic                      upd_tgl; // toggles on each new result
	logic                      cs_n;    // chip select pin, raw
	logic                      rc;      // read/convert pin, raw
	logic                      tag;     // daisy-chain pin, raw
	logic                      ser_bit; // serial bit from the link side

	modport core (
		output word,
		output upd_tgl,
		output cs_n,
		output rc,
		output tag,
		input  ser_bit
	);

	modport link (
		input  word,
		input  upd_tgl,
		input  cs_n,
		input  rc,
		input  tag,
		output ser_bit
	);

endinterface : acp_link_if

// *** rtl/acp_link_shift.sv ***
// serial shifter clocked by the externally supplied shift clock
`timescale 1ns/1ps
module acp_link_shift (
	input wire logic link_clk_in, // external serial shift clock
	input wire logic nrst_in,     // async reset, active low
	acp_link_if.link lk           // link to the core
);
	import acp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [2:0]           tgl_s; // result toggle sync plus history
		logic [1:0]           cs_s;  // chip select sync
		logic [1:0]           rc_s;  // read/convert sync
		logic [1:0]           tag_s; // daisy-chain sync
		logic [RES_W-1:0]     word;  // captured result
		logic [RES_W-1:0]     shreg; // output shift register
		logic [BIT_CNT_W-1:0] cnt;   // bits shifted this frame
		logic                 sbit;  // bit handed to the core
	} acp_link_t;

	acp_link_t r_r;   // registered state
	acp_link_t r_nxt; // next state
	logic      frame; // host is reading serially

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		r_nxt = r_r;
		r_nxt.tgl_s = {r_r.tgl_s[1:0], lk.upd_tgl};
		r_nxt.cs_s  = {r_r.cs_s[0], lk.cs_n};
		r_nxt.rc_s  = {r_r.rc_s[0], lk.rc};
		r_nxt.tag_s = {r_r.tag_s[0], lk.tag};
		frame = !r_r.cs_s[1] && r_r.rc_s[1];
		// word is stable long before its toggle arrives here
		if (r_r.tgl_s[2] != r_r.tgl_s[1]) begin
			r_nxt.word = lk.word;
		end
		if (!frame) begin
			// rearm: next frame starts again at the msb
			r_nxt.cnt   = '0;
			r_nxt.shreg = r_nxt.word;
		end else if (r_r.cnt != BIT_CNT_W'(N_BITS)) begin
			// msb first, one bit per shift clock
			r_nxt.cnt   = r_r.cnt + BIT_CNT_W'(1);
			r_nxt.shreg = {r_r.shreg[MSB-1:0], 1'b0};
		end
		// after the last bit the daisy-chain level follows
		if (r_nxt.cnt == BIT_CNT_W'(N_BITS)) begin
			r_nxt.sbit = r_r.tag_s[1];
		end else begin
			r_nxt.sbit = r_nxt.shreg[MSB];
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge link_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign lk.ser_bit = r_r.sbit;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking lcb @(posedge link_clk_in);
	endclocking
	default disable iff (!nrst_in);

	tag_pass_a: assert property (
		frame && r_r.cnt >= BIT_CNT_W'(N_BITS - 1)
		|-> r_nxt.sbit == r_r.tag_s[1])
		else $error("daisy-chain level not passed after last bit");

	msb_first_a: assert property (
		frame && r_r.cnt < BIT_CNT_W'(N_BITS - 1)
		|=> r_r.sbit == $past(r_r.shreg[MSB-1]))
		else $error("serial bit order wrong");

endmodule : acp_link_shift

// *** verif/acp_host_model.sv ***
// host-side model that clocks results out of the port in external mode
`timescale 1ns/1ps
module acp_host_model (
	input  wire logic        go_in,   // start one read frame
	input  wire logic        sdo_in,  // serial result line from the port
	output logic             sck_out, // external shift clock
	output logic [16:0]      rx_out,  // 16 result bits, then chain level
	output logic             done_out // frame finished
);
	localparam realtime HALF = 80.0; // half of the 160 ns shift clock

	////////////////////////////////////////////////////////////////////////
	// idle: the clock stands still low between frames
	initial begin
		sck_out  = 1'b0;
		rx_out   = '0;
		done_out = 1'b0;
	end

	// two lead pulses let the port see the frame, the rest shift data out;
	// each bit is taken before the next rise, once the port has settled
	always @(posedge go_in) begin
		done_out = 1'b0;
		#23.3;
		for (int i = 0; i < 18; i++) begin
			sck_out = 1'b1;
			#HALF;
			sck_out = 1'b0;
			if (i >= 1) begin
				rx_out = {rx_out[15:0], sdo_in};
			end
			#HALF;
		end
		done_out = 1'b1;
	end
endmodule : acp_host_model

// *** verif/test_acp_conv_port.sv ***
// self-checking bench for the conversion output port
`timescale 1ns/1ps
module test_acp_conv_port;
	import acp_pkg::*;
	localparam int CONV = 20; // shortened conversion length
	localparam int QTR  = 1;  // shortened burst quarter
	logic              sys_clk_in  = 1'b0; // system clock
	logic              nrst_in     = 1'b0; // reset, active low
	logic              cs_n_in     = 1'b1; // chip select
	logic              rc_in       = 1'b1; // read/convert
	logic              byte_sel_in = 1'b0; // byte lane select
	logic              clk_src     = 1'b1; // 1: external shift clock
	logic              fmt_in      = 1'b1; // 1: straight binary
	logic              pd_in       = 1'b0; // power-down
	logic              tag_in      = 1'b0; // daisy-chain level
	logic              go          = 1'b0; // host frame start
	logic [RES_W-1:0]  smp         = '0;   // core result
	logic [BYTE_W-1:0] pdata;              // parallel bus
	logic              poe;                // bus enable
	logic              busy_n;             // busy, active low
	logic              sck_o;              // generated shift clock
	logic              sck_oe;             // shift clock pin drive
	logic              sdo;                // serial result
	logic              hsck;               // host shift clock
	logic [16:0]       hrx;                // host received bits
	logic              hdone;              // host frame done
	logic              sck_q       = 1'b0; // last shift clock level
	logic [15:0]       int_rx      = '0;   // bits taken on burst rises
	int                rise_cnt    = 0;    // burst rising edges
	int                fall_bad    = 0;    // bits moved at a fall
	int                lo_cnt      = 0;    // cycles with busy low
	int                cyc         = 0;    // timeout counter
	int                error_cnt   = 0;    // mismatches
	int                cmp_count   = 0;    // comparisons

	acp_conv_port #(.CONV_CYC(CONV), .QTR_CYC(QTR)) dut (
		.sys_clk_in               (sys_clk_in),
		.nrst_in                  (nrst_in),
		.cs_n_in                  (cs_n_in),
		.rc_in                    (rc_in),
		.byte_sel_in              (byte_sel_in),
		.clock_source_select_in   (clk_src),
		.output_format_select_in  (fmt_in),
		.power_down_in            (pd_in),
		.tag_in                   (tag_in),
		.serial_shift_clock_in    (hsck),
		.sample_data_in           (smp),
		.parallel_data_out        (pdata),
		.parallel_oe_out          (poe),
		.busy_n_out               (busy_n),
		.serial_shift_clock_out   (sck_o),
		.serial_shift_clock_oe_out(sck_oe),
		.serial_result_out        (sdo)
	);

	acp_host_model host (
		.go_in   (go),
		.sdo_in  (sdo),
		.sck_out (hsck),
		.rx_out  (hrx),
		.done_out(hdone)
	);

	////////////////////////////////////////////////////////////////////////
	// clock, timeout, busy and burst monitors
	always #2 sys_clk_in = ~sys_clk_in;

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			results();
		end
	end

	// monitors look at the outputs half a cycle after they launch
	always @(negedge sys_clk_in) begin
		if (busy_n === 1'b0) lo_cnt++;
		sck_q <= sck_o;
		if (sck_o === 1'b1 && sck_q === 1'b0) begin
			rise_cnt <= rise_cnt + 1;
			int_rx   <= {int_rx[14:0], sdo};
		end
		if (sck_o === 1'b0 && sck_q === 1'b1 && sdo !== int_rx[0]) begin
			fall_bad <= fall_bad + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : tick

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results

	// one conversion, started by chip select or by read/convert
	task automatic conv(input logic by_cs, input logic retrig);
		int w;
		w = 0;
		lo_cnt = 0;
		if (by_cs) begin
			rc_in = 1'b0;
			tick(3);
			cs_n_in = 1'b0;
		end else begin
			cs_n_in = 1'b0;
			tick(3);
			rc_in = 1'b0;
		end
		while (busy_n !== 1'b0 && w < 10) begin
			tick(1);
			w++;
		end
		if (w == 10) error_cnt++; // start wait ran out
		chk(17'(busy_n), 17'h0_0000);
		chk(17'(poe), 17'h0_0000);
		cs_n_in = 1'b1;
		rc_in = 1'b1;
		if (retrig) begin
			tick(3);
			cs_n_in = 1'b0;
			rc_in = 1'b0;
			tick(4);
			cs_n_in = 1'b1;
			rc_in = 1'b1;
		end
		w = 0;
		while (busy_n !== 1'b1 && w < 300) begin
			tick(1);
			w++;
		end
		if (w == 300) error_cnt++; // done wait ran out
		tick(10);
	endtask : conv

	// both bytes of the parallel bus, then release
	task automatic rd_par(input logic [15:0] exp);
		cs_n_in = 1'b0;
		byte_sel_in = 1'b0;
		tick(4);
		chk(17'(poe), 17'h0_0001);
		chk(17'(pdata), 17'(exp[15:8]));
		byte_sel_in = 1'b1;
		tick(4);
		chk(17'(pdata), 17'(exp[7:0]));
		cs_n_in = 1'b1;
		tick(4);
		chk(17'(poe), 17'h0_0000);
	endtask : rd_par

	// one host frame of the external shift clock
	task automatic frame;
		int w;
		w = 0;
		go = 1'b1;
		tick(2);
		go = 1'b0;
		while (hdone !== 1'b1 && w < 2000) begin
			tick(1);
			w++;
		end
		if (w == 2000) error_cnt++; // frame wait ran out
	endtask : frame

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_par;
		smp = 16'ha53c;
		conv(1'b0, 1'b0);
		chk(17'(lo_cnt), 17'(CONV));
		rd_par(16'ha53c);
		fmt_in = 1'b0;
		smp = 16'h1234;
		conv(1'b1, 1'b1);
		chk(17'(lo_cnt), 17'(CONV));
		rd_par(16'h9234);
	endtask : s_par

	task automatic s_pd;
		pd_in = 1'b1;
		smp = 16'h5a5a;
		tick(4);
		lo_cnt = 0;
		cs_n_in = 1'b0;
		tick(3);
		rc_in = 1'b0;
		tick(10);
		chk(17'(lo_cnt), 17'h0_0000);
		cs_n_in = 1'b1;
		rc_in = 1'b1;
		pd_in = 1'b0;
		tick(4);
		rd_par(16'h9234);
	endtask : s_pd

	task automatic s_ser;
		tag_in = 1'b1;
		smp = 16'hc3e1;
		conv(1'b0, 1'b0);
		frame(); // deselected: lets the link side pick up the new result
		cs_n_in = 1'b0;
		tick(4);
		frame();
		chk(hrx, {16'h43e1, 1'b1});
		chk(17'(sck_oe), 17'h0_0000);
		cs_n_in = 1'b1;
		tick(4);
	endtask : s_ser

	task automatic s_int;
		clk_src = 1'b0;
		smp = 16'h0f0f;
		tick(4);
		chk(17'(rise_cnt), 17'h0_0000);
		conv(1'b0, 1'b0);
		chk(17'(lo_cnt), 17'(64 * QTR));
		chk(17'(rise_cnt), 17'h0_0010);
		chk(17'(int_rx), 17'h0_43e1);
		chk(17'(fall_bad), 17'h0_0000);
		chk(17'(sck_oe), 17'h0_0001);
		tag_in = 1'b0;
		tick(6);
		chk(17'({sck_o, sdo}), 17'h0_0001);
		smp = 16'hffff;
		conv(1'b1, 1'b0);
		chk(17'(int_rx), 17'h0_8f0f);
		chk(17'({sck_o, sdo}), 17'h0_0000);
	endtask : s_int

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		tick(8);
		nrst_in = 1'b1;
		tick(4);
		s_par();
		s_pd();
		s_ser();
		s_int();
		results();
	end
endmodule : test_acp_conv_port
